// ==== sbm_pkg.sv ====
// package: register map, reset values and write masks of the bank map
package sbm_pkg;

    // ------------------------------------------------------------
    // map geometry
    // ------------------------------------------------------------
    localparam int          NREG       = 24;
    localparam int          ADDR_W     = 10;
    localparam int          DATA_W     = 32;
    localparam logic [9:0]  MODE_IDX   = 10'h3F0; // serial mode select copy
    localparam logic [9:0]  WIN_BASE   = 10'h200; // direct window, bank from status
    localparam logic [6:0]  SLOT_LOC   = 7'h00;   // indirect access slot
    localparam logic [6:0]  PCL_LOC    = 7'h02;
    localparam logic [3:0]  MASK_MODE  = 4'h9;    // mode that shows the mask
    localparam int          PC_HI_W    = 5;

    // ------------------------------------------------------------
    // entry numbers used by the logic
    // ------------------------------------------------------------
    localparam int E_SLAVE_ADR = 5;
    localparam int E_ADR_MASK  = 6;
    localparam int E_STATUS    = 16;
    localparam int E_POINTER   = 17;
    localparam int E_HI_LATCH  = 20;

    // ------------------------------------------------------------
    // per entry: data address, mirrored flag, reset value, write mask
    // entry 0 is the rightmost element
    // ------------------------------------------------------------
    localparam logic [NREG-1:0][8:0] IDX = {
        9'h10D, 9'h10C, 9'h10B, 9'h10A, 9'h109, 9'h108, 9'h104, 9'h103,
        9'h101, 9'h09F, 9'h09D, 9'h09C, 9'h099, 9'h098, 9'h096, 9'h095,
        9'h094, 9'h093, 9'h093, 9'h092, 9'h091, 9'h090, 9'h08F, 9'h08E};
    localparam logic [NREG-1:0] CORE = 24'h330000; // status, pointer, latch, interrupt_control only
    // unknown bits load as zero; condition-dependent bits as below
    localparam logic [NREG-1:0][7:0] RST = {
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h18,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'hFF,
        8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h20, 8'h00, 8'h03};
    localparam logic [NREG-1:0][7:0] WMASK = {
        8'hFF, 8'hFF, 8'hFF, 8'h1F, 8'h0F, 8'h8D, 8'hFF, 8'hE7,
        8'hFF, 8'h73, 8'h43, 8'h03, 8'hFF, 8'hF5, 8'hFF, 8'hFF,
        8'hC0, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'h30, 8'hFB, 8'h03};

endpackage

// ==== sbm_bank_map.sv ====
// module: special-function register bank map behind an avalon-mm slave
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none

module sbm_bank_map #(
    parameter int P_DATA_W = sbm_pkg::DATA_W
) (
    input  wire logic                          i_clk_sys,
    input  wire logic                          i_rst_n,
    input  wire logic [sbm_pkg::ADDR_W-1:0]    i_avs_address,
    input  wire logic                          i_avs_read,
    input  wire logic                          i_avs_write,
    input  wire logic [3:0]                    i_avs_byteenable,
    input  wire logic [P_DATA_W-1:0]           i_avs_writedata,
    output logic      [P_DATA_W-1:0]           o_avs_readdata,
    output logic                               o_avs_waitrequest,
    output logic      [12:0]                   o_pc
);

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    if (P_DATA_W != sbm_pkg::DATA_W) begin : g_bad_width
        $error("data width must be 32");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [sbm_pkg::NREG-1:0][7:0] regs;
        logic [sbm_pkg::PC_HI_W-1:0]   pc_hi;
        logic [7:0]                    pc_lo;
        logic [3:0]                    mode;
        logic                          waitreq;
        logic [7:0]                    rdata;
        logic                          hit;
    } sbm_state_s;

    localparam sbm_state_s ST_RST = '{
        regs:    sbm_pkg::RST,
        pc_hi:   '0,
        pc_lo:   '0,
        mode:    '0,
        waitreq: 1'b1,
        rdata:   '0,
        hit:     1'b0
    };

    sbm_state_s                  st_q;
    sbm_state_s                  st_d;
    logic                        rst_meta_q;
    logic                        rst_sync_q;
    logic [8:0]                  win_a;
    logic [8:0]                  eff_a;
    logic                        valid_a;
    logic                        via_slot;
    logic                        no_loc;
    logic                        pcl_hit;
    logic                        mode_hit;
    logic [sbm_pkg::NREG-1:0]    hit_v;
    logic [7:0]                  rd_mux;
    logic                        req;
    logic                        take;
    logic                        ack;
    logic                        wr_ack;
    logic [7:0]                  wdat;
    logic [7:0]                  status;
    logic [7:0]                  pointer;

    // ------------------------------------------------------------
    // reset release through two flops
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------
    // handshake terms
    // ------------------------------------------------------------
    // a request is taken while waitrequest is high, answered the next cycle
    assign req     = i_avs_read | i_avs_write;
    assign take    = req & st_q.waitreq;
    assign ack     = req & ~st_q.waitreq;
    assign wr_ack  = ack & i_avs_write & i_avs_byteenable[0];
    assign wdat    = i_avs_writedata[7:0];
    assign status  = st_q.regs[sbm_pkg::E_STATUS];
    assign pointer = st_q.regs[sbm_pkg::E_POINTER];

    // ------------------------------------------------------------
    // address resolution
    // ------------------------------------------------------------
    // window addresses take the bank from the direct bank field
    always_comb begin
        valid_a = ~i_avs_address[9] |
                  (i_avs_address[9:7] == sbm_pkg::WIN_BASE[9:7]);
        if (i_avs_address[9]) begin
            win_a = {status[6:5], i_avs_address[6:0]};
        end else begin
            win_a = i_avs_address[8:0];
        end
        via_slot = (win_a[6:0] == sbm_pkg::SLOT_LOC);
        // the slot redirects through the pointer, bank pair from bit 7
        if (via_slot) begin
            eff_a = {status[7], pointer};
        end else begin
            eff_a = win_a;
        end
        // slot through slot, or bad window, is no location at all
        no_loc   = ~valid_a | (eff_a[6:0] == sbm_pkg::SLOT_LOC);
        pcl_hit  = ~no_loc & (eff_a[6:0] == sbm_pkg::PCL_LOC);
        mode_hit = (i_avs_address == sbm_pkg::MODE_IDX);
    end

    // per-entry decode; mirrored entries ignore the bank bits
    for (genvar gi = 0; gi < sbm_pkg::NREG; gi++) begin : g_dec
        logic match;
        logic sel_ok;
        assign match = sbm_pkg::CORE[gi] ?
                       (eff_a[6:0] == sbm_pkg::IDX[gi][6:0]) :
                       (eff_a == sbm_pkg::IDX[gi]);
        if (gi == sbm_pkg::E_ADR_MASK) begin : g_msk
            assign sel_ok = (st_q.mode == sbm_pkg::MASK_MODE);
        end else if (gi == sbm_pkg::E_SLAVE_ADR) begin : g_sla
            assign sel_ok = (st_q.mode != sbm_pkg::MASK_MODE);
        end else begin : g_any
            assign sel_ok = 1'b1;
        end
        assign hit_v[gi] = ~no_loc & match & sel_ok;
    end

    // ------------------------------------------------------------
    // read multiplexer
    // ------------------------------------------------------------
    // misses fall through to zero
    always_comb begin
        rd_mux = 8'h00;
        for (int k = 0; k < sbm_pkg::NREG; k++) begin
            if (hit_v[k]) begin
                rd_mux = st_q.regs[k];
            end
        end
        if (pcl_hit) begin
            rd_mux = st_q.pc_lo;
        end
        if (mode_hit) begin
            rd_mux = {4'h0, st_q.mode};
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        if (take) begin
            st_d.waitreq = 1'b0;
            st_d.rdata   = rd_mux;
            st_d.hit     = (|hit_v) | pcl_hit | mode_hit;
        end
        if (ack) begin
            st_d.waitreq = 1'b1;
        end
        // writes land at the edge that closes the request
        if (wr_ack) begin
            for (int k = 0; k < sbm_pkg::NREG; k++) begin
                if (hit_v[k]) begin
                    st_d.regs[k] = (st_q.regs[k] & ~sbm_pkg::WMASK[k]) |
                                   (wdat & sbm_pkg::WMASK[k]);
                end
            end
            // low byte write pulls the latch into the upper counter
            if (pcl_hit) begin
                st_d.pc_lo = wdat;
                st_d.pc_hi = st_q.regs[sbm_pkg::E_HI_LATCH][4:0];
            end
            if (mode_hit) begin
                st_d.mode = wdat[3:0];
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // reset pattern is a constant image, q bits fixed there
    always_ff @(posedge i_clk_sys or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            st_q <= ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_avs_waitrequest = st_q.waitreq;
    assign o_avs_readdata    = {{(P_DATA_W-8){1'b0}}, st_q.rdata};
    assign o_pc              = {st_q.pc_hi, st_q.pc_lo};

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!rst_sync_q);

    unmapped_zero_a: assert property (
        (take & i_avs_read & ~((|hit_v) | pcl_hit | mode_hit))
        |=> (o_avs_readdata == '0))
        else $error("unmapped read not zero");

    mirror_alias_a: assert property (
        (take & i_avs_read & (i_avs_address == 10'h183))
        |=> (o_avs_readdata[7:0] == $past(status)))
        else $error("status mirror mismatch");

    mask_select_a: assert property (
        (wr_ack & (i_avs_address == 10'h093) & (st_q.mode == 4'h9))
        |=> (st_q.regs[6] == $past(wdat)) && $stable(st_q.regs[5]))
        else $error("shared location wrong target");

    hi_hidden_a: assert property (
        $changed(st_q.pc_hi) |-> $past(wr_ack & pcl_hit))
        else $error("upper counter changed without low write");

    latch_defer_a: assert property (
        (wr_ack & hit_v[20]) |=> $stable(st_q.pc_hi))
        else $error("latch write moved counter");

    latch_xfer_a: assert property (
        (wr_ack & pcl_hit) |=> (o_pc[12:8] == $past(st_q.regs[20][4:0])))
        else $error("latch not moved on low write");

    reset_image_a: assert property (
        $rose(rst_sync_q) |-> (st_q.regs[4] == 8'hFF) && (status == 8'h18))
        else $error("reset pattern wrong");

    direct_bank_a: assert property (
        (take & i_avs_read & (i_avs_address == 10'h20D) & (status[6:5] == 2'b10))
        |=> (o_avs_readdata[7:0] == $past(st_q.regs[23])))
        else $error("direct bank decode wrong");

    indirect_bank_a: assert property (
        (take & i_avs_read & (i_avs_address == 10'h000) & status[7] &
         (pointer == 8'h0C))
        |=> (o_avs_readdata[7:0] == $past(st_q.regs[22])))
        else $error("indirect bank decode wrong");

    ro_bits_a: assert property (
        (wr_ack & hit_v[7]) |=> (st_q.regs[7][5:0] == $past(st_q.regs[7][5:0])))
        else $error("read-only bits written");

    answer_one_a: assert property (
        take |=> ~o_avs_waitrequest ##1 o_avs_waitrequest)
        else $error("answer not one cycle");

    // ------------------------------------------------------------
    // checks on unimplemented bits and dropped writes
    // ------------------------------------------------------------
    // bits with no storage behind them must never pick up a one
    osc_unused_a: assert property (
        (st_q.regs[2] & 8'hC3) == 8'h00)
        else $error("unimplemented oscillator bits set");

    write_drop_a: assert property (
        (wr_ack & ~((|hit_v) | pcl_hit | mode_hit))
        |=> $stable(st_q.regs) && $stable(st_q.pc_lo) && $stable(st_q.mode))
        else $error("unmapped write changed storage");

    // ------------------------------------------------------------
    // checks on mirrors and the shared serial location
    // ------------------------------------------------------------
    // a write in any bank must land in the one shared copy
    status_write_a: assert property (
        (wr_ack & ~i_avs_address[9] & (i_avs_address[6:0] == 7'h03))
        |=> (status == (($past(status) & 8'h18) | ($past(wdat) & 8'hE7))))
        else $error("status mirror write lost");

    pointer_write_a: assert property (
        (wr_ack & ~i_avs_address[9] & (i_avs_address[6:0] == 7'h04))
        |=> (pointer == $past(wdat)))
        else $error("pointer mirror write lost");

    slave_select_a: assert property (
        (wr_ack & (i_avs_address == 10'h093) & (st_q.mode != 4'h9))
        |=> (st_q.regs[5] == $past(wdat)) && $stable(st_q.regs[6]))
        else $error("shared location wrong target");

    mode_store_a: assert property (
        (wr_ack & mode_hit) |=> (st_q.mode == $past(wdat[3:0])))
        else $error("serial mode not stored");

    mode_read_a: assert property (
        (take & i_avs_read & mode_hit)
        |=> (o_avs_readdata[7:0] == {4'h0, $past(st_q.mode)}))
        else $error("serial mode read wrong");

    // ------------------------------------------------------------
    // checks on the program counter path
    // ------------------------------------------------------------
    // the low byte is the only door into the counter from the bus
    low_only_a: assert property (
        $changed(st_q.pc_lo) |-> $past(wr_ack & pcl_hit))
        else $error("counter low changed without write");

    pc_read_a: assert property (
        (take & i_avs_read & pcl_hit)
        |=> (o_avs_readdata[7:0] == $past(st_q.pc_lo)))
        else $error("counter low read wrong");

    latch_upper_a: assert property (
        st_q.regs[sbm_pkg::E_HI_LATCH][7:5] == 3'b000)
        else $error("latch holds more than five bits");

    // ------------------------------------------------------------
    // checks on reset, bank selection and read-only status flags
    // ------------------------------------------------------------
    reset_defaults_a: assert property (
        $rose(rst_sync_q) |-> (st_q.regs[0] == 8'h03) && (st_q.regs[2] == 8'h20) &&
        (st_q.regs[6] == 8'hFF) && (st_q.mode == 4'h0) && (o_pc == 13'h0000))
        else $error("reset defaults wrong");

    bank_one_a: assert property (
        (take & i_avs_read & (i_avs_address == 10'h212) & (status[6:5] == 2'b01))
        |=> (o_avs_readdata[7:0] == $past(st_q.regs[4])))
        else $error("bank one window wrong");

    bank_three_a: assert property (
        (take & i_avs_read & (i_avs_address == 10'h203) & (status[6:5] == 2'b11))
        |=> (o_avs_readdata[7:0] == $past(status)))
        else $error("bank three window wrong");

    low_pair_a: assert property (
        (take & i_avs_read & (i_avs_address == 10'h200) & ~status[7] &
         (pointer == 8'h8E))
        |=> (o_avs_readdata[7:0] == $past(st_q.regs[0])))
        else $error("low bank pair decode wrong");

    // a pointer back at the slot must not loop, it reads as nothing
    slot_loop_a: assert property (
        (take & i_avs_read & via_slot & (pointer[6:0] == 7'h00))
        |=> (o_avs_readdata == '0))
        else $error("slot through slot not zero");

    ro_status_a: assert property (
        (wr_ack & hit_v[sbm_pkg::E_STATUS]) |=> (status[4:3] == $past(status[4:3])))
        else $error("status flags written");

    read_seen_c:  cover property (take & i_avs_read ##1 ~o_avs_waitrequest);
    write_seen_c: cover property (wr_ack & hit_v[0]);
    ind_read_c:   cover property (take & i_avs_read & via_slot & ~no_loc);
    mask_used_c:  cover property (wr_ack & hit_v[6]);
    slave_used_c: cover property (wr_ack & hit_v[5]);

endmodule

`default_nettype wire

// ==== sbm_core_model.sv ====
// partner model: core data-memory access master on the avalon-mm port
`timescale 1ns/1ps
`default_nettype none
module sbm_core_model (
    input  wire logic        i_clk_sys,
    input  wire logic [31:0] i_readdata,
    input  wire logic        i_waitrequest,
    output var  logic [9:0]  o_address,
    output var  logic        o_read,
    output var  logic        o_write,
    output var  logic [3:0]  o_byteenable,
    output var  logic [31:0] o_writedata
);
    // idle bus at time zero
    initial begin
        o_address    = 10'h000;
        o_read       = 1'b0;
        o_write      = 1'b0;
        o_byteenable = 4'h1;
        o_writedata  = 32'h0000_0000;
    end

    // ------------------------------------------------------------
    // one access, held until waitrequest is seen low, for at most 20 edges
    // ------------------------------------------------------------
    // sampled right after the edge, so the slave's own update cannot race us
    task automatic access(input logic wr, input logic [9:0] addr, input logic [7:0] data,
                          output logic [31:0] rdata, output logic ok);
        int n;
        ok = 1'b0;
        rdata = 32'h0000_0000;
        o_address   <= addr;
        o_writedata <= {24'h000000, data};
        o_read      <= ~wr;
        o_write     <= wr;
        for (n = 0; n < 20 && !ok; n++) begin
            @(posedge i_clk_sys);
            if (i_waitrequest === 1'b0) begin
                ok = 1'b1;
                rdata = i_readdata;
            end
        end
        o_read      <= 1'b0;
        o_write     <= 1'b0;
        o_address   <= ~addr;   // released lines show stale-free junk
        o_writedata <= ~{24'h000000, data};
        @(posedge i_clk_sys);
    endtask
endmodule
`default_nettype wire

// ==== testbench.sv ====
// testbench: reset image, masks, mirrors, serial share, counter latch, banks
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk_sys;
    logic        rst_n;
    logic [9:0]  address;
    logic        read;
    logic        write;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [12:0] pc;
    int          err_count = 0;
    int          total_checks = 0;

    sbm_bank_map i_sbm_bank_map (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_avs_address(address),
        .i_avs_read(read), .i_avs_write(write), .i_avs_byteenable(byteenable),
        .i_avs_writedata(writedata), .o_avs_readdata(readdata),
        .o_avs_waitrequest(waitrequest), .o_pc(pc));
    sbm_core_model i_sbm_core_model (.i_clk_sys(clk_sys), .i_readdata(readdata),
        .i_waitrequest(waitrequest), .o_address(address), .o_read(read), .o_write(write),
        .o_byteenable(byteenable), .o_writedata(writedata));

    // 100 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic test_done();
        if (err_count == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // a missing answer is a mismatch and ends the run
    task automatic xfer(input logic wr, input logic [9:0] a, input logic [7:0] d,
                        output logic [31:0] q);
        logic ok;
        i_sbm_core_model.access(wr, a, d, q, ok);
        if (ok !== 1'b1) begin
            err_count++;
            test_done();
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    // upper readdata bits must read zero as well
    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 8'h00, q);
        check(q, {24'h000000, e});
    endtask

    // reset image, read-only bits and unmapped places
    task automatic scn_reset_map();
        rd(10'h08E, 8'h03);
        rd(10'h092, 8'hFF);
        rd(10'h095, 8'hFF);
        rd(10'h098, 8'h02);
        rd(10'h103, 8'h18);
        rd(10'h097, 8'h00);
        rd(10'h30F, 8'h00);
        wr(10'h090, 8'hFF);
        rd(10'h090, 8'h30);
        wr(10'h09C, 8'hFF);
        rd(10'h09C, 8'h03);
        wr(10'h08E, 8'hFF);
        rd(10'h08E, 8'h03);
        wr(10'h094, 8'hFF);
        rd(10'h094, 8'hC0);
        wr(10'h097, 8'hFF);
        rd(10'h097, 8'h00);
    endtask

    // core registers seen through every bank
    task automatic scn_mirror();
        wr(10'h084, 8'h5A);
        rd(10'h004, 8'h5A);
        rd(10'h104, 8'h5A);
        rd(10'h184, 8'h5A);
        wr(10'h18B, 8'hC3);
        rd(10'h08B, 8'hC3);
        rd(10'h18E, 8'h00);
        rd(10'h183, 8'h18);
        wr(10'h109, 8'h05);
        rd(10'h109, 8'h05);
        rd(10'h089, 8'h00);
    endtask

    // shared location follows the serial mode; mode 8 differs by one bit
    task automatic scn_serial();
        wr(10'h093, 8'h12);
        wr(10'h3F0, 8'h09);
        rd(10'h093, 8'hFF);
        wr(10'h093, 8'h34);
        wr(10'h3F0, 8'h08);
        rd(10'h093, 8'h12);
        wr(10'h3F0, 8'h09);
        rd(10'h093, 8'h34);
        rd(10'h3F0, 8'h09);
    endtask

    // latch alone leaves the counter; low-byte write moves it
    task automatic scn_counter();
        wr(10'h10A, 8'hFF);
        rd(10'h18A, 8'h1F);
        check({19'h0, pc}, 32'h0000_0000);
        wr(10'h082, 8'hA5);
        check({19'h0, pc}, 32'h0000_1FA5);
        rd(10'h102, 8'hA5);
    endtask

    // window bank from the direct field, slot from the indirect bit
    task automatic scn_banks();
        wr(10'h003, 8'h20);
        rd(10'h212, 8'hFF);
        wr(10'h103, 8'h40);
        wr(10'h20D, 8'h6C);
        rd(10'h20D, 8'h6C);
        rd(10'h10D, 8'h6C);
        wr(10'h183, 8'h60);
        rd(10'h20E, 8'h00);
        rd(10'h203, 8'h78);
        wr(10'h004, 8'h8E);
        rd(10'h200, 8'h03);
        wr(10'h003, 8'h80);
        wr(10'h004, 8'h0D);
        rd(10'h200, 8'h6C);
        rd(10'h080, 8'h6C);
        wr(10'h004, 8'h00);
        rd(10'h100, 8'h00);
        wr(10'h10C, 8'h3C);
        wr(10'h004, 8'h0C);
        rd(10'h000, 8'h3C);
    endtask

    // a second reset in mid-run brings the whole image back
    task automatic scn_reset_again();
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        check({19'h0, pc}, 32'h0000_0000);
        rd(10'h093, 8'h00);
        rd(10'h3F0, 8'h00);
        rd(10'h08B, 8'h00);
        rd(10'h103, 8'h18);
    endtask

    // reset 20 cycles, first request on the third edge after release
    initial begin
        rst_n <= 1'b0;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        scn_reset_map();
        scn_mirror();
        scn_serial();
        scn_counter();
        scn_banks();
        scn_reset_again();
        test_done();
    end
endmodule
`default_nettype wire
